// >>> iosec_bus_master.sv
// Purpose: Two-wire bus master that writes or reads the switch enable byte
// Assumes: No clock stretching by the slave
// Notes:   Serial clock made by dividing clk_i, four quarters per bit
`timescale 1ns/1ps
module iosec_bus_master (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Request
  input  wire logic       go_i,
  input  wire logic       rw_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [2:0] count_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       dev_reset_req_i,
  // Answer
  output logic            busy_o,
  output logic            done_o,
  output logic            nack_o,
  output logic            byte_req_o,
  output logic [7:0]      rdata_o,
  output logic            rdata_valid_o,
  // Serial link
  iosec_if.master         bus
);

  iosec_pkg::iosec_mst_state_t state_reg;
  logic [1:0]                  sda_sync_reg;
  logic [5:0]                  qcnt_reg;
  logic [1:0]                  qph_reg;
  logic [3:0]                  bit_reg;
  logic [8:0]                  tx_reg;
  logic [7:0]                  rx_reg;
  logic [2:0]                  left_reg;
  logic                        first_reg;
  logic                        rw_reg;
  logic                        ack_reg;
  logic                        scl_oe_n_reg;
  logic                        sda_oe_n_reg;
  logic                        rst_pin_n_reg;
  logic                        tick;

  assign tick = (qcnt_reg == iosec_pkg::QTR_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_sync_reg  <= iosec_pkg::SYNC_IDLE;
      rst_pin_n_reg <= 1'b1;
    end else begin
      sda_sync_reg  <= {sda_sync_reg[0], bus.sda};
      rst_pin_n_reg <= ~dev_reset_req_i;
    end
  end

  // Quarter-bit divider
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg == iosec_pkg::IOSEC_M_IDLE || tick) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + 6'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= iosec_pkg::IOSEC_M_IDLE;
      qph_reg       <= iosec_pkg::PH_LOW;
      bit_reg       <= '0;
      tx_reg        <= '0;
      rx_reg        <= '0;
      left_reg      <= '0;
      first_reg     <= 1'b0;
      rw_reg        <= 1'b0;
      ack_reg       <= 1'b0;
      scl_oe_n_reg  <= 1'b1;
      sda_oe_n_reg  <= 1'b1;
      busy_o        <= 1'b0;
      done_o        <= 1'b0;
      nack_o        <= 1'b0;
      byte_req_o    <= 1'b0;
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
    end else begin
      done_o        <= 1'b0;
      byte_req_o    <= 1'b0;
      rdata_valid_o <= 1'b0;
      case (state_reg)
        iosec_pkg::IOSEC_M_IDLE: begin
          if (go_i) begin
            state_reg <= iosec_pkg::IOSEC_M_START;
            qph_reg   <= iosec_pkg::PH_LOW;
            busy_o    <= 1'b1;
            nack_o    <= 1'b0;
            rw_reg    <= rw_i;
            left_reg  <= count_i;
            first_reg <= 1'b1;
            // Address byte first, direction in its last bit
            tx_reg    <= {addr_i, rw_i, 1'b1};
          end
        end
        iosec_pkg::IOSEC_M_START: begin
          if (tick) begin
            qph_reg <= qph_reg + 2'h1;
            if (qph_reg == iosec_pkg::PH_LOW) begin
              sda_oe_n_reg <= 1'b0;
            end else if (qph_reg == iosec_pkg::PH_RISE) begin
              scl_oe_n_reg <= 1'b0;
            end else begin
              state_reg    <= iosec_pkg::IOSEC_M_BIT;
              qph_reg      <= iosec_pkg::PH_LOW;
              bit_reg      <= '0;
              sda_oe_n_reg <= tx_reg[8];
            end
          end
        end
        iosec_pkg::IOSEC_M_BIT: begin
          if (tick) begin
            qph_reg <= qph_reg + 2'h1;
            case (qph_reg)
              iosec_pkg::PH_LOW: begin
                scl_oe_n_reg <= 1'b1;
              end
              iosec_pkg::PH_RISE: begin
                if (bit_reg == iosec_pkg::BYTE_BITS) begin
                  ack_reg <= sda_sync_reg[1];
                end else begin
                  rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
                end
              end
              iosec_pkg::PH_HIGH: begin
                scl_oe_n_reg <= 1'b0;
              end
              default: begin
                if (bit_reg != iosec_pkg::BYTE_BITS) begin
                  bit_reg      <= bit_reg + 4'h1;
                  tx_reg       <= {tx_reg[7:0], 1'b1};
                  sda_oe_n_reg <= tx_reg[7];
                end else begin
                  bit_reg <= '0;
                  first_reg <= 1'b0;
                  if (!first_reg && rw_reg) begin
                    rdata_o       <= rx_reg;
                    rdata_valid_o <= 1'b1;
                  end
                  if (ack_reg != iosec_pkg::ACK_LEVEL && !(rw_reg && !first_reg)) begin
                    nack_o       <= 1'b1;
                    state_reg    <= iosec_pkg::IOSEC_M_STOP;
                    qph_reg      <= iosec_pkg::PH_LOW;
                    sda_oe_n_reg <= 1'b0;
                  end else if (!first_reg && left_reg <= iosec_pkg::ONE_LEFT) begin
                    state_reg    <= iosec_pkg::IOSEC_M_STOP;
                    qph_reg      <= iosec_pkg::PH_LOW;
                    sda_oe_n_reg <= 1'b0;
                  end else begin
                    if (!first_reg) begin
                      left_reg <= left_reg - 3'h1;
                    end
                    if (rw_reg) begin
                      // Withhold acknowledge on the last byte read
                      tx_reg <= {iosec_pkg::READ_FILL,
                                 (first_reg ? left_reg : left_reg - 3'h1) <= iosec_pkg::ONE_LEFT};
                      sda_oe_n_reg <= 1'b1;
                    end else begin
                      tx_reg       <= {wdata_i, 1'b1};
                      sda_oe_n_reg <= wdata_i[7];
                      byte_req_o   <= 1'b1;
                    end
                  end
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            qph_reg <= qph_reg + 2'h1;
            if (qph_reg == iosec_pkg::PH_LOW) begin
              scl_oe_n_reg <= 1'b1;
            end else if (qph_reg == iosec_pkg::PH_RISE) begin
              sda_oe_n_reg <= 1'b1;
            end else begin
              state_reg <= iosec_pkg::IOSEC_M_IDLE;
              busy_o    <= 1'b0;
              done_o    <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign bus.m_scl_o    = 1'b0;
  assign bus.m_sda_o    = 1'b0;
  assign bus.m_scl_oe_n = scl_oe_n_reg;
  assign bus.m_sda_oe_n = sda_oe_n_reg;
  assign bus.rst_pin_n  = rst_pin_n_reg;

endmodule

// >>> iosec_pkg.sv
// Purpose: Shared constants and state types for the serial switch-enable link
// Assumes: 100 MHz system clock on both ends
// Notes:   Fixed upper address bits are a plain default
package iosec_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  // Quarter bit time, least time so round up
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);

  localparam logic [3:0] ADDR_UPPER   = 4'h7;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] FIRST_BIT    = 4'h1;
  localparam logic       DIR_READ     = 1'b1;
  localparam logic       ACK_LEVEL    = 1'b0;
  localparam logic [7:0] READ_FILL    = 8'hff;
  localparam logic [2:0] ONE_LEFT     = 3'h1;
  localparam logic [1:0] SYNC_IDLE    = 2'h3;
  localparam logic [1:0] PH_LOW       = 2'h0;
  localparam logic [1:0] PH_RISE      = 2'h1;
  localparam logic [1:0] PH_HIGH      = 2'h2;
  localparam logic [1:0] PH_FALL      = 2'h3;

  typedef enum logic [2:0] {
    IOSEC_D_IDLE     = 3'h0,
    IOSEC_D_ADDR     = 3'h1,
    IOSEC_D_ADDR_ACK = 3'h3,
    IOSEC_D_WR       = 3'h2,
    IOSEC_D_WR_ACK   = 3'h6,
    IOSEC_D_RD       = 3'h7,
    IOSEC_D_RD_ACK   = 3'h5
  } iosec_dev_state_t;

  typedef enum logic [1:0] {
    IOSEC_M_IDLE  = 2'h0,
    IOSEC_M_START = 2'h1,
    IOSEC_M_BIT   = 2'h3,
    IOSEC_M_STOP  = 2'h2
  } iosec_mst_state_t;
endpackage

// >>> iosec_if.sv
// Purpose: Two-wire link plus reset pin between bus master and switch device
// Assumes: Both lines pulled up; enables active low
// Notes:   Resolves open-drain levels from the enables
`timescale 1ns/1ps
interface iosec_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic rst_pin_n;
  logic scl;
  logic sda;

  assign scl = m_scl_oe_n | m_scl_o;
  assign sda = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);

  modport master (
    output m_scl_o, m_scl_oe_n, m_sda_o, m_sda_oe_n, rst_pin_n,
    input  scl, sda
  );
  modport device (
    output d_sda_o, d_sda_oe_n,
    input  scl, sda, rst_pin_n
  );
endinterface

// >>> iosec_switch_dev.sv
// Purpose: Serial slave holding the eight-channel switch enable byte
// Assumes: System clock far faster than the serial clock
// Notes:   Serial lines, reset pin and address pins are synchronised first
//
// Summary of operation
// - Bit one closes its channel switch
// - Bit zero opens its channel switch
// - Reset pin low idles engine, opens switches
// - Three select pins form low address bits
// - Last address bit: one read, zero write
// - Data byte after address stored in control
// - Several bytes: last one is kept
// - Control register writable and readable
// - New pattern applies when acknowledge is driven
// - Write selects channels, read returns status
// - Each bit drives its own channel
// - Power-up with every channel open
// - Any serial rate up to fast mode
// - System ties select pins high or low
// - Master sends address first after start
// - Master holds reset pin low long enough
// - Reset leaves control zero, engine idle
// - Pull data low in acknowledge clock
`timescale 1ns/1ps
module iosec_switch_dev (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Address select straps
  input  wire logic       addr_select_0_i,
  input  wire logic       addr_select_1_i,
  input  wire logic       addr_select_2_i,
  // Switch enables, chan1_enable_bit at bit 0
  output logic [7:0]      chan_enable_o,
  // Serial link
  iosec_if.device         bus
);

  logic [1:0]                  scl_sync_reg;
  logic [1:0]                  sda_sync_reg;
  logic [1:0]                  rpin_sync_reg;
  logic [2:0]                  asel_meta_reg;
  logic [2:0]                  asel_reg;
  logic                        scl_prev_reg;
  logic                        sda_prev_reg;
  logic                        scl_s;
  logic                        sda_s;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_cond;
  logic                        stop_cond;
  logic                        eng_rst;
  logic [6:0]                  own_addr;
  iosec_pkg::iosec_dev_state_t state_reg;
  logic [7:0]                  shift_reg;
  logic [3:0]                  bits_reg;
  logic                        dir_reg;
  logic                        mack_reg;
  logic                        sda_oe_n_reg;
  logic                        sda_out_reg;
  logic [7:0]                  channel_enable_control_reg;
  logic                        byte_done;
  logic                        commit;

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync_reg  <= iosec_pkg::SYNC_IDLE;
      sda_sync_reg  <= iosec_pkg::SYNC_IDLE;
      rpin_sync_reg <= iosec_pkg::SYNC_IDLE;
      asel_meta_reg <= '0;
      asel_reg      <= '0;
    end else begin
      scl_sync_reg  <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg  <= {sda_sync_reg[0], bus.sda};
      rpin_sync_reg <= {rpin_sync_reg[0], bus.rst_pin_n};
      asel_meta_reg <= {addr_select_2_i, addr_select_1_i, addr_select_0_i};
      asel_reg      <= asel_meta_reg;
    end
  end

  // Previous synchronised levels for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_s      = scl_sync_reg[1];
  assign sda_s      = sda_sync_reg[1];
  // Edges are found from samples, so no minimum serial rate applies
  assign scl_rise   = scl_s & ~scl_prev_reg;
  assign scl_fall   = ~scl_s & scl_prev_reg;
  assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign eng_rst    = rst_i | ~rpin_sync_reg[1];
  assign own_addr   = {iosec_pkg::ADDR_UPPER, asel_reg};
  assign byte_done  = scl_fall & (bits_reg == iosec_pkg::BYTE_BITS);
  assign commit     = (state_reg == iosec_pkg::IOSEC_D_WR) & byte_done;

  // Serial engine
  always_ff @(posedge clk_i) begin
    if (eng_rst) begin
      state_reg    <= iosec_pkg::IOSEC_D_IDLE;
      shift_reg    <= '0;
      bits_reg     <= '0;
      dir_reg      <= 1'b0;
      mack_reg     <= 1'b0;
      sda_oe_n_reg <= 1'b1;
    end else if (start_cond) begin
      state_reg    <= iosec_pkg::IOSEC_D_ADDR;
      bits_reg     <= '0;
      sda_oe_n_reg <= 1'b1;
    end else if (stop_cond) begin
      state_reg    <= iosec_pkg::IOSEC_D_IDLE;
      sda_oe_n_reg <= 1'b1;
    end else begin
      case (state_reg)
        iosec_pkg::IOSEC_D_ADDR, iosec_pkg::IOSEC_D_WR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bits_reg  <= bits_reg + 4'h1;
          end else if (byte_done) begin
            bits_reg <= '0;
            if (state_reg == iosec_pkg::IOSEC_D_WR) begin
              state_reg    <= iosec_pkg::IOSEC_D_WR_ACK;
              sda_oe_n_reg <= 1'b0;
            end else if (shift_reg[7:1] == own_addr) begin
              state_reg    <= iosec_pkg::IOSEC_D_ADDR_ACK;
              dir_reg      <= shift_reg[0];
              sda_oe_n_reg <= 1'b0;
            end else begin
              state_reg    <= iosec_pkg::IOSEC_D_IDLE;
            end
          end
        end
        iosec_pkg::IOSEC_D_ADDR_ACK: begin
          if (scl_fall) begin
            if (dir_reg == iosec_pkg::DIR_READ) begin
              state_reg    <= iosec_pkg::IOSEC_D_RD;
              sda_oe_n_reg <= channel_enable_control_reg[7];
              shift_reg    <= {channel_enable_control_reg[6:0], 1'b0};
              bits_reg     <= iosec_pkg::FIRST_BIT;
            end else begin
              state_reg    <= iosec_pkg::IOSEC_D_WR;
              sda_oe_n_reg <= 1'b1;
            end
          end
        end
        iosec_pkg::IOSEC_D_WR_ACK: begin
          if (scl_fall) begin
            state_reg    <= iosec_pkg::IOSEC_D_WR;
            sda_oe_n_reg <= 1'b1;
          end
        end
        iosec_pkg::IOSEC_D_RD: begin
          if (byte_done) begin
            state_reg    <= iosec_pkg::IOSEC_D_RD_ACK;
            sda_oe_n_reg <= 1'b1;
            bits_reg     <= '0;
          end else if (scl_fall) begin
            sda_oe_n_reg <= shift_reg[7];
            shift_reg    <= {shift_reg[6:0], 1'b0};
            bits_reg     <= bits_reg + 4'h1;
          end
        end
        iosec_pkg::IOSEC_D_RD_ACK: begin
          if (scl_rise) begin
            mack_reg <= (sda_s == iosec_pkg::ACK_LEVEL);
          end else if (scl_fall) begin
            if (mack_reg) begin
              state_reg    <= iosec_pkg::IOSEC_D_RD;
              sda_oe_n_reg <= channel_enable_control_reg[7];
              shift_reg    <= {channel_enable_control_reg[6:0], 1'b0};
              bits_reg     <= iosec_pkg::FIRST_BIT;
            end else begin
              // Master withheld acknowledge: line stays released
              state_reg <= iosec_pkg::IOSEC_D_IDLE;
            end
          end
        end
        default: begin
          sda_oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // Control byte; loaded on the edge that drives the acknowledge
  always_ff @(posedge clk_i) begin
    if (eng_rst) begin
      channel_enable_control_reg <= iosec_pkg::CTRL_RESET;
    end else if (commit) begin
      channel_enable_control_reg <= shift_reg;
    end
  end

  // Open-drain data driver only ever pulls low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  // Each bit steers its own channel: 1 closes, 0 opens
  assign chan_enable_o  = channel_enable_control_reg;
  assign bus.d_sda_o    = sda_out_reg;
  assign bus.d_sda_oe_n = sda_oe_n_reg;

endmodule

// >>> iosec_sva.sv
// Purpose: Protocol checks on the two-wire link between master and switch device
// Assumes: Interface signals seen as plain inputs, sync reset rst_i
// Notes:   Instantiated beside the interface by the bench
`timescale 1ns/1ps
module iosec_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_oe_n,
  input wire logic m_sda_oe_n,
  input wire logic d_sda_oe_n,
  input wire logic rst_pin_n
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_pin_reset_release: assert property (!rst_pin_n [*4] |-> d_sda_oe_n)
    else $error("device holds sda while reset pin low");
  a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n))
    else $error("device sda changed while scl high");
  a_dev_answer_lag: assert property ($changed(d_sda_oe_n) && rst_pin_n && $past(rst_pin_n, 6)
    |-> !$past(scl, 1) && !$past(scl, 2) && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
    else $error("device sda change not 2 to 4 cycles after scl fall");
  a_ack_stands: assert property (@(posedge clk_i) disable iff (rst_i || !rst_pin_n)
    $fell(d_sda_oe_n) |-> !d_sda_oe_n [*8])
    else $error("device low pulse too short");
  a_start_by_master: assert property (scl && $past(scl) && $fell(sda) |-> d_sda_oe_n && !m_sda_oe_n)
    else $error("start not made by master");
  a_stop_released: assert property (scl && $past(scl) && $rose(sda) |-> d_sda_oe_n [*8])
    else $error("device drives sda after stop");
  a_scl_low_time: assert property ($fell(m_scl_oe_n) |-> !m_scl_oe_n [*8])
    else $error("scl low phase too short");
  a_scl_high_time: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");

  c_start: cover property (scl && $fell(sda));
  c_dev_ack: cover property ($fell(d_sda_oe_n));
  c_stop: cover property (scl && $rose(sda));
  c_pin_reset: cover property ($fell(rst_pin_n));
endmodule

// >>> i2c_octal_switch_enable_ctrl_tb.sv
// Purpose: Self-checking bench joining bus master and switch device
// Assumes: 100 MHz clock, master divides its own serial clock
// Notes:   Straps driven by the bench so every select value is reached
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module i2c_octal_switch_enable_ctrl_tb;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [2:0] sel = 3'h5;
  logic [7:0] chan_enable_o;
  logic       go_i = 1'b0;
  logic       rw_i = 1'b0;
  logic [6:0] addr_i = 7'h00;
  logic [2:0] count_i = 3'h1;
  logic [7:0] wdata_i = 8'h00;
  logic       dev_reset_req_i = 1'b0;
  logic       busy_o;
  logic       done_o;
  logic       nack_o;
  logic       byte_req_o;
  logic [7:0] rdata_o;
  logic       rdata_valid_o;
  logic [7:0] wbuf [0:7];
  logic [7:0] rbuf [0:7];
  int         widx = 0;
  int         ridx = 0;
  logic       dev_drove = 1'b0;
  logic       clr = 1'b0;
  int         bad_count = 0;
  int         check_count = 0;

  always #5 clk_i = ~clk_i;

  iosec_if bus_if ();
  iosec_switch_dev iosec_switch_dev_inst (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .addr_select_0_i (sel[0]),
    .addr_select_1_i (sel[1]),
    .addr_select_2_i (sel[2]),
    .chan_enable_o   (chan_enable_o),
    .bus             (bus_if)
  );
  iosec_bus_master iosec_bus_master_inst (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .go_i            (go_i),
    .rw_i            (rw_i),
    .addr_i          (addr_i),
    .count_i         (count_i),
    .wdata_i         (wdata_i),
    .dev_reset_req_i (dev_reset_req_i),
    .busy_o          (busy_o),
    .done_o          (done_o),
    .nack_o          (nack_o),
    .byte_req_o      (byte_req_o),
    .rdata_o         (rdata_o),
    .rdata_valid_o   (rdata_valid_o),
    .bus             (bus_if)
  );
  iosec_sva iosec_sva_inst (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .scl        (bus_if.scl),
    .sda        (bus_if.sda),
    .m_scl_oe_n (bus_if.m_scl_oe_n),
    .m_sda_oe_n (bus_if.m_sda_oe_n),
    .d_sda_oe_n (bus_if.d_sda_oe_n),
    .rst_pin_n  (bus_if.rst_pin_n)
  );

  // Next write byte after each take, read bytes collected
  always @(posedge clk_i) begin
    if (clr) begin
      widx      <= 0;
      ridx      <= 0;
      dev_drove <= 1'b0;
      wdata_i   <= wbuf[0];
    end else begin
      if (byte_req_o === 1'b1) begin
        widx <= widx + 1;
        wdata_i <= wbuf[(widx + 1) % 8];
      end
      if (rdata_valid_o === 1'b1) begin
        rbuf[ridx % 8] <= rdata_o;
        ridx <= ridx + 1;
      end
      if (bus_if.d_sda_oe_n === 1'b0) begin
        dev_drove <= 1'b1;
      end
    end
  end

  task automatic final_report();
    if (bad_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic run(input logic rw, input logic [6:0] addr, input logic [2:0] cnt);
    int n;
    @(posedge clk_i);
    go_i <= 1'b1;
    rw_i <= rw;
    addr_i <= addr;
    count_i <= cnt;
    clr <= 1'b1;
    @(posedge clk_i);
    go_i <= 1'b0;
    clr <= 1'b0;
    n = 0;
    #1;
    `CHK("busy during", 1'b1, busy_o)
    while (done_o !== 1'b1 && n < 40000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 40000) begin
      bad_count++;
      final_report();
    end
    `CHK("busy after", 1'b0, busy_o)
  endtask

  task automatic t_power_up();
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("power-up enable", iosec_pkg::CTRL_RESET, chan_enable_o)
    `CHK("power-up sda", 1'b1, bus_if.d_sda_oe_n)
  endtask

  function automatic logic [6:0] own(input logic [2:0] s);
    return {iosec_pkg::ADDR_UPPER, s};
  endfunction

  // Pattern applies only once the ack is on the bus
  task automatic t_write_one();
    int n;
    wbuf[0] = 8'h4c;
    fork
      run(1'b0, own(sel), 3'h1);
      begin
        n = 0;
        @(posedge clk_i);
        #1;
        while (chan_enable_o === 8'h00 && n < 40000) begin
          @(posedge clk_i);
          #1;
          n++;
        end
        if (n >= 40000) begin
          bad_count++;
          final_report();
        end
        `CHK("ack at commit", 1'b0, bus_if.d_sda_oe_n)
        `CHK("scl at commit", 1'b0, bus_if.scl)
      end
    join
    `CHK("write nack", 1'b0, nack_o)
    `CHK("enable after write", 8'h4c, chan_enable_o)
  endtask

  task automatic t_write_multi();
    wbuf[0] = 8'ha5;
    wbuf[1] = 8'h3c;
    wbuf[2] = 8'h81;
    run(1'b0, own(sel), 3'h3);
    `CHK("multi nack", 1'b0, nack_o)
    `CHK("last byte kept", 8'h81, chan_enable_o)
  endtask

  task automatic t_read();
    run(1'b1, own(sel), 3'h3);
    `CHK("read count", 3, ridx)
    for (int i = 0; i < 3; i++) begin
      `CHK("read byte", 8'h81, rbuf[i])
    end
    `CHK("read leaves enable", 8'h81, chan_enable_o)
  endtask

  task automatic t_wrong_addr();
    wbuf[0] = 8'hff;
    run(1'b0, own(sel ^ 3'h4), 3'h1);
    `CHK("foreign nack", 1'b1, nack_o)
    `CHK("foreign no drive", 1'b0, dev_drove)
    `CHK("foreign no change", 8'h81, chan_enable_o)
  endtask

  // Walk each channel alone, each select strap value
  task automatic t_straps_walk();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      sel <= 3'(i);
      repeat (4) @(posedge clk_i);
      wbuf[0] = 8'h01 << i;
      run(1'b0, own(3'(i)), 3'h1);
      `CHK("strap ack", 1'b0, nack_o)
      `CHK("single channel", 8'h01 << i, chan_enable_o)
    end
  endtask

  task automatic t_pin_reset();
    @(posedge clk_i);
    dev_reset_req_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    dev_reset_req_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    `CHK("pin reset opens", 8'h00, chan_enable_o)
    wbuf[0] = 8'h5a;
    run(1'b0, own(sel), 3'h1);
    `CHK("idle after pin reset", 8'h5a, chan_enable_o)
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power_up();
    t_write_one();
    t_write_multi();
    t_read();
    t_wrong_addr();
    t_straps_walk();
    t_pin_reset();
    final_report();
  end
endmodule
